// ===== hw/chan_cfg_regs.sv
// Channel B/C/D configuration registers behind the serial management port
`timescale 1ns/1ps
module chan_cfg_regs
    import chan_cfg_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h00
) (
    // Clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // Management port pins
    input wire logic i_mgmt_clk,
    input wire logic i_mgmt_data,
    output logic o_mgmt_data,
    output logic o_mgmt_data_oe,
    // Global bits held elsewhere
    input wire logic i_glb_loopback,
    input wire logic i_glb_power_down,
    input wire logic i_glb_pattern_test,
    input wire logic i_glb_comma_detect,
    // Effective per-channel controls, index 0 = B
    output logic [NUM_CHAN-1:0] o_loss_of_signal_en,
    output logic [NUM_CHAN-1:0] o_cfg_select_hi,
    output logic [NUM_CHAN-1:0] o_cfg_select_lo,
    output logic [NUM_CHAN-1:0] o_emphasis_ctl_hi,
    output logic [NUM_CHAN-1:0] o_emphasis_ctl_lo,
    output logic [NUM_CHAN-1:0] o_loopback,
    output logic [NUM_CHAN-1:0] o_pattern_test,
    output logic [NUM_CHAN-1:0] o_comma_detect,
    output logic [NUM_CHAN-1:0] o_power_down
);

    typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_TA, ST_DATA} mgmt_st_t;

    // Register number to channel index; 3 means not ours
    function automatic logic [1:0] chan_of(input logic [4:0] reg_num);
        unique case (reg_num)
            CHAN_B_CONFIG_ADDR: chan_of = 2'h0;
            CHAN_C_CONFIG_ADDR: chan_of = 2'h1;
            CHAN_D_CONFIG_ADDR: chan_of = 2'h2;
            default: chan_of = 2'h3;
        endcase
    endfunction

    // ==========================================================
    // Pin synchronisers: three stages, change taken when 2 and 3 agree
    logic [2:0] mdc_sync_reg;
    logic [2:0] mdio_sync_reg;
    logic mdc_reg;
    logic mdio_reg;
    logic mdc_rise;
    logic mdc_fall;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            mdc_sync_reg <= 3'h0;
            mdio_sync_reg <= 3'h7;
            mdc_reg <= 1'b0;
            mdio_reg <= 1'b1;
        end else if (i_clk_en) begin
            mdc_sync_reg <= {mdc_sync_reg[1:0], i_mgmt_clk};
            mdio_sync_reg <= {mdio_sync_reg[1:0], i_mgmt_data};
            if (mdc_sync_reg[1] == mdc_sync_reg[2]) begin
                mdc_reg <= mdc_sync_reg[2];
            end
            if (mdio_sync_reg[1] == mdio_sync_reg[2]) begin
                mdio_reg <= mdio_sync_reg[2];
            end
        end
    end

    assign mdc_rise = (mdc_sync_reg[1] == mdc_sync_reg[2])
                      && mdc_sync_reg[2] && !mdc_reg;
    assign mdc_fall = (mdc_sync_reg[1] == mdc_sync_reg[2])
                      && !mdc_sync_reg[2] && mdc_reg;

    // ==========================================================
    // Management frame engine
    mgmt_st_t state_reg;
    logic [5:0] pre_cnt_reg;
    logic [4:0] bit_cnt_reg;
    logic [13:0] hdr_reg;
    logic [15:0] shift_reg;
    logic is_read_reg;
    logic hit_reg;
    logic [1:0] chan_reg;
    logic wr_stb;
    logic [15:0] cfg_reg [NUM_CHAN];

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_reg <= ST_IDLE;
            pre_cnt_reg <= 6'h00;
            bit_cnt_reg <= 5'h00;
            hdr_reg <= 14'h0000;
            shift_reg <= 16'h0000;
            is_read_reg <= 1'b0;
            hit_reg <= 1'b0;
            chan_reg <= 2'h3;
        end else if (i_clk_en && mdc_rise) begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (mdio_reg) begin
                        if (pre_cnt_reg != MGMT_PRE_MIN) begin
                            pre_cnt_reg <= pre_cnt_reg + 6'h01;
                        end
                    end else begin
                        // First start bit after a full preamble
                        if (pre_cnt_reg == MGMT_PRE_MIN) begin
                            state_reg <= ST_HDR;
                            hdr_reg <= 14'h0000;
                            bit_cnt_reg <= 5'h00;
                        end
                        pre_cnt_reg <= 6'h00;
                    end
                end
                ST_HDR: begin
                    hdr_reg <= {hdr_reg[12:0], mdio_reg};
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    if (bit_cnt_reg == 5'(MGMT_HDR_BITS - 2)) begin
                        // 13 bits seen: start [11], op [10:9], phy [8:4]
                        chan_reg <= chan_of({hdr_reg[3:0], mdio_reg});
                        hit_reg <= (hdr_reg[8:4] == PHY_ADDR)
                                   && (hdr_reg[11] == MGMT_START[0]);
                        is_read_reg <= (hdr_reg[10:9] == MGMT_OP_READ);
                        if (hdr_reg[10:9] != MGMT_OP_READ
                            && hdr_reg[10:9] != MGMT_OP_WRITE) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            state_reg <= ST_TA;
                            bit_cnt_reg <= 5'h00;
                        end
                    end
                end
                ST_TA: begin
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    if (bit_cnt_reg == 5'h01) begin
                        state_reg <= ST_DATA;
                        bit_cnt_reg <= 5'h00;
                        shift_reg <= (chan_reg == 2'h3) ? 16'h0000
                                     : cfg_reg[chan_reg];
                    end
                end
                ST_DATA: begin
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    if (is_read_reg) begin
                        shift_reg <= {shift_reg[14:0], 1'b0};
                    end else begin
                        shift_reg <= {shift_reg[14:0], mdio_reg};
                    end
                    if (bit_cnt_reg == 5'(MGMT_DATA_BITS - 1)) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Write strobe on the last data bit; data completed in flight
    assign wr_stb = i_clk_en && mdc_rise && state_reg == ST_DATA
                    && !is_read_reg && hit_reg && chan_reg != 2'h3
                    && bit_cnt_reg == 5'(MGMT_DATA_BITS - 1);

    // Read data changes on falling edge so it is stable at the rising one
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_mgmt_data <= 1'b0;
            o_mgmt_data_oe <= 1'b0;
        end else if (i_clk_en && mdc_fall) begin
            if (is_read_reg && hit_reg && state_reg == ST_TA
                && bit_cnt_reg == 5'h01) begin
                o_mgmt_data_oe <= 1'b1;
                o_mgmt_data <= 1'b0;
            end else if (is_read_reg && hit_reg && state_reg == ST_DATA) begin
                o_mgmt_data_oe <= 1'b1;
                o_mgmt_data <= shift_reg[15];
            end else begin
                o_mgmt_data_oe <= 1'b0;
                o_mgmt_data <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Channel registers and effective controls
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        always_ff @(posedge i_clk_sys) begin
            if (!i_rst_n) begin
                cfg_reg[c] <= CFG_RESET; // R02 R03 R04 R05 R06 R07 R08
            end else if (i_clk_en && wr_stb && chan_reg == 2'(c)) begin
                // Bits 15:9 stay zero
                cfg_reg[c] <= {shift_reg[14:0], mdio_reg}
                              & CFG_WRITE_MASK; // R01
            end
        end

        always_ff @(posedge i_clk_sys) begin
            if (!i_rst_n) begin
                o_loss_of_signal_en[c] <= CFG_RESET[LOSS_OF_SIGNAL_BIT];
                o_cfg_select_hi[c] <= 1'b0;
                o_cfg_select_lo[c] <= 1'b0;
                o_emphasis_ctl_hi[c] <= 1'b0;
                o_emphasis_ctl_lo[c] <= 1'b0;
                o_loopback[c] <= 1'b0;
                o_pattern_test[c] <= GLB_PATTERN_RESET; // R10
                o_comma_detect[c] <= GLB_COMMA_RESET; // R09
                o_power_down[c] <= 1'b0;
            end else if (i_clk_en) begin
                o_loss_of_signal_en[c] <=
                    cfg_reg[c][LOSS_OF_SIGNAL_BIT]; // R02
                o_cfg_select_hi[c] <= cfg_reg[c][CFG_SELECT_HI_BIT]; // R03
                o_cfg_select_lo[c] <= cfg_reg[c][CFG_SELECT_LO_BIT]; // R03
                o_emphasis_ctl_hi[c] <=
                    cfg_reg[c][EMPHASIS_CTL_HI_BIT]; // R04
                o_emphasis_ctl_lo[c] <=
                    cfg_reg[c][EMPHASIS_CTL_LO_BIT]; // R04
                o_loopback[c] <= cfg_reg[c][LOOPBACK_BIT]
                                 | i_glb_loopback; // R05
                o_pattern_test[c] <= cfg_reg[c][PATTERN_TEST_BIT]
                                     | i_glb_pattern_test; // R06 R10
                o_comma_detect[c] <= cfg_reg[c][COMMA_DETECT_BIT]
                                     | i_glb_comma_detect; // R07 R09
                o_power_down[c] <= cfg_reg[c][POWER_DOWN_BIT]
                                   | i_glb_power_down; // R08
            end
        end
    end

endmodule

// ===== hw/chan_cfg_pkg.sv
// Constants for the per-channel configuration register bank
// Summary of operation
// [R01] Channels B, C and D each have one 16-bit config register at 18, 19, 20 with the same layout.
// [R02] Bit 8 enables loss-of-signal reporting, resets to 1.
// [R03] Bits 7 and 6 are the config selection bits, reset to 0.
// [R04] Bits 5 and 4 are the preemphasis control bits, reset to 0.
// [R05] Bit 3 enables loopback, reset 0, ORed with global bit 0.14.
// [R06] Bit 2 enables pattern test, reset 0, ORed with global bit 16.2.
// [R07] Bit 1 enables comma detection, reset 1, ORed with global bit 16.1.
// [R08] Bit 0 powers the channel down, reset 0, ORed with global bit 0.11.
// [R09] The global comma detect enable resets to 1 and enables all channels.
// [R10] The global pattern test enable resets to 0 and enables all channels.
package chan_cfg_pkg;
    // ==========================================================
    // Register map
    localparam int NUM_CHAN = 3;
    localparam logic [4:0] CHAN_B_CONFIG_ADDR = 5'h12;
    localparam logic [4:0] CHAN_C_CONFIG_ADDR = 5'h13;
    localparam logic [4:0] CHAN_D_CONFIG_ADDR = 5'h14;
    // ==========================================================
    // Field positions
    localparam int LOSS_OF_SIGNAL_BIT = 8;
    localparam int CFG_SELECT_HI_BIT = 7;
    localparam int CFG_SELECT_LO_BIT = 6;
    localparam int EMPHASIS_CTL_HI_BIT = 5;
    localparam int EMPHASIS_CTL_LO_BIT = 4;
    localparam int LOOPBACK_BIT = 3;
    localparam int PATTERN_TEST_BIT = 2;
    localparam int COMMA_DETECT_BIT = 1;
    localparam int POWER_DOWN_BIT = 0;
    localparam logic [15:0] CFG_WRITE_MASK = 16'h01ff;
    // ==========================================================
    // Reset values
    localparam logic [15:0] CFG_RESET = 16'h0102;
    localparam logic GLB_COMMA_RESET = 1'b1;
    localparam logic GLB_PATTERN_RESET = 1'b0;
    // ==========================================================
    // Management frame
    localparam logic [1:0] MGMT_START = 2'h1;
    localparam logic [1:0] MGMT_OP_WRITE = 2'h1;
    localparam logic [1:0] MGMT_OP_READ = 2'h2;
    localparam logic [5:0] MGMT_PRE_MIN = 6'h20;
    localparam int MGMT_HDR_BITS = 14;
    localparam int MGMT_DATA_BITS = 16;
endpackage

// ===== tb/chan_cfg_checker.sv
// Port assertions for the channel configuration bank
`timescale 1ns/1ps
module chan_cfg_checker (
    // Clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // Management pin outputs
    input wire logic o_mgmt_data,
    input wire logic o_mgmt_data_oe,
    // Global bits
    input wire logic i_glb_loopback,
    input wire logic i_glb_power_down,
    input wire logic i_glb_pattern_test,
    input wire logic i_glb_comma_detect,
    // Effective controls
    input wire logic [2:0] o_loss_of_signal_en,
    input wire logic [2:0] o_cfg_select_hi,
    input wire logic [2:0] o_cfg_select_lo,
    input wire logic [2:0] o_emphasis_ctl_hi,
    input wire logic [2:0] o_emphasis_ctl_lo,
    input wire logic [2:0] o_loopback,
    input wire logic [2:0] o_pattern_test,
    input wire logic [2:0] o_comma_detect,
    input wire logic [2:0] o_power_down
);
    wire [14:0] plain = {o_loss_of_signal_en, o_cfg_select_hi,
        o_cfg_select_lo, o_emphasis_ctl_hi, o_emphasis_ctl_lo};
    wire [11:0] ored = {o_loopback, o_pattern_test, o_comma_detect,
        o_power_down};
    wire [3:0] glb = {i_glb_loopback, i_glb_power_down,
        i_glb_pattern_test, i_glb_comma_detect};
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // ==========================================================
    // Read turnaround
    sequence s_drive_open;
        $rose(o_mgmt_data_oe);
    endsequence
    sequence s_drive_held;
        o_mgmt_data_oe [*8];
    endsequence
    a_ta_zero: assert property (s_drive_open |-> !o_mgmt_data)
        else $error("turnaround bit not zero");
    a_drive_holds: assert property (s_drive_open |-> s_drive_held)
        else $error("read drive dropped early");
    // ==========================================================
    // Global OR terms
    a_loop_or: assert property (i_glb_loopback && i_clk_en
        |=> o_loopback == 3'h7)
        else $error("loopback not forced");
    a_pattern_or: assert property (i_glb_pattern_test && i_clk_en
        |=> o_pattern_test == 3'h7)
        else $error("pattern test not forced");
    a_comma_or: assert property (i_glb_comma_detect && i_clk_en
        |=> o_comma_detect == 3'h7)
        else $error("comma detect not forced");
    a_pdn_or: assert property (i_glb_power_down && i_clk_en
        |=> o_power_down == 3'h7)
        else $error("power down not forced");
    a_fields_isolated: assert property ($changed(glb) |=> $stable(plain))
        else $error("plain fields follow globals");
    // ==========================================================
    // Reset and freeze
    a_reset_state: assert property ($rose(i_rst_n)
        |-> plain == 15'h7000)
        else $error("wrong reset outputs");
    a_freeze_hold: assert property (!i_clk_en
        |=> $stable({plain, ored, o_mgmt_data_oe}))
        else $error("outputs moved while frozen");
endmodule
bind chan_cfg_regs chan_cfg_checker u_chk (.i_clk_sys, .i_rst_n,
    .i_clk_en, .o_mgmt_data, .o_mgmt_data_oe, .i_glb_loopback,
    .i_glb_power_down, .i_glb_pattern_test, .i_glb_comma_detect,
    .o_loss_of_signal_en, .o_cfg_select_hi, .o_cfg_select_lo,
    .o_emphasis_ctl_hi, .o_emphasis_ctl_lo, .o_loopback,
    .o_pattern_test, .o_comma_detect, .o_power_down);

// ===== tb/mgmt_host_model.sv
// Management controller model that clocks frames into the bank
`timescale 1ns/1ps
module mgmt_host_model
    import chan_cfg_pkg::*;
(
    // Clock
    input wire logic i_clk_sys,
    // Serial management pins
    input wire logic i_line,
    output logic o_mdc,
    output logic o_drv
);
    initial begin
        o_mdc = 1'b0;
        o_drv = 1'b1;
    end
    // Half period of 10 clocks clears the 8-clock minimum
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
        input logic [4:0] rg, input logic [15:0] wd,
        output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hffff_ffff, MGMT_START, op, phy, rg, 18'h3ffff};
        if (op == MGMT_OP_WRITE) f[17:0] = {2'h2, wd};
        for (int i = 63; i >= 0; i--) begin
            @(posedge i_clk_sys) o_drv <= f[i];
            repeat (10) @(posedge i_clk_sys);
            o_mdc <= 1'b1;
            rd = {rd[14:0], i_line};
            repeat (10) @(posedge i_clk_sys);
            o_mdc <= 1'b0;
        end
        // Release: the pull-up idles the line high
        @(posedge i_clk_sys) o_drv <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
    endtask
endmodule

// ===== tb/per_channel_config_regs_bench.sv
// Self-checking bench for the channel configuration bank
`timescale 1ns/1ps
module per_channel_config_regs_bench;
    import chan_cfg_pkg::*;
    localparam logic [4:0] PA = 5'h05;
    logic i_clk_sys, i_rst_n, i_clk_en, g_lb, g_pd, g_pt, g_cd;
    logic mdc, drv, line, d_out, d_oe;
    logic [2:0] loss_of_signal, sh, sl, eh, el, lb, pt, cd, pd;
    logic [15:0] rd;
    logic [15:0] vals [3] = '{16'hffff, 16'h000d, 16'h01f0};
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    // Open-drain line: either party pulls low
    assign line = drv & (d_oe ? d_out : 1'b1);
    chan_cfg_regs #(.PHY_ADDR(PA)) u_dut (.i_clk_sys, .i_rst_n,
        .i_clk_en, .i_mgmt_clk(mdc), .i_mgmt_data(line),
        .o_mgmt_data(d_out), .o_mgmt_data_oe(d_oe),
        .i_glb_loopback(g_lb), .i_glb_power_down(g_pd),
        .i_glb_pattern_test(g_pt), .i_glb_comma_detect(g_cd),
        .o_loss_of_signal_en(loss_of_signal), .o_cfg_select_hi(sh),
        .o_cfg_select_lo(sl), .o_emphasis_ctl_hi(eh),
        .o_emphasis_ctl_lo(el), .o_loopback(lb), .o_pattern_test(pt),
        .o_comma_detect(cd), .o_power_down(pd));
    mgmt_host_model u_host (.i_clk_sys, .i_line(line), .o_mdc(mdc),
        .o_drv(drv));
    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end
    task automatic results();
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors = n_errors + 1;
            results();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] outs(int i);
        return {7'h0, loss_of_signal[i], sh[i], sl[i], eh[i], el[i], lb[i], pt[i],
            cd[i], pd[i]};
    endfunction
    task automatic wr(input logic [4:0] ph, rg, input logic [15:0] v);
        u_host.xfer(MGMT_OP_WRITE, ph, rg, v, rd);
    endtask
    task automatic rdchk(input logic [4:0] ph, rg, input logic [15:0] e);
        u_host.xfer(MGMT_OP_READ, ph, rg, 16'h0, rd);
        chk(rd, e);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        i_rst_n <= 1'b0;
        i_clk_en <= 1'b1;
        {g_lb, g_pd, g_pt, g_cd} <= 4'h1;
        repeat (6) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rdchk(PA, CHAN_B_CONFIG_ADDR + 5'(i), 16'h0102);
        end
        chk(outs(1), 16'h0102);
        @(posedge i_clk_sys) g_cd <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            wr(PA, CHAN_B_CONFIG_ADDR + 5'(i), vals[i]);
        end
        for (int i = 0; i < 3; i++) begin
            rdchk(PA, CHAN_B_CONFIG_ADDR + 5'(i), vals[i] & 16'h01ff);
            chk(outs(i), vals[i] & 16'h01ff);
        end
        @(posedge i_clk_sys) {g_lb, g_pd, g_pt, g_cd} <= 4'hf;
        repeat (2) @(posedge i_clk_sys);
        for (int i = 0; i < 3; i++) begin
            chk(outs(i), (vals[i] & 16'h01ff) | 16'h000f);
        end
        chk(outs(2), 16'h01ff);
        @(posedge i_clk_sys) {g_lb, g_pd, g_pt, g_cd} <= 4'h2;
        repeat (2) @(posedge i_clk_sys);
        chk(outs(2), 16'h01f4);
        chk(outs(1), 16'h000d);
        wr(PA, 5'h15, 16'h0001);
        rdchk(PA, 5'h15, 16'h0000);
        wr(5'h06, 5'h12, 16'h0000);
        rdchk(PA, 5'h12, 16'h01ff);
        rdchk(5'h06, 5'h12, 16'hffff);
        @(posedge i_clk_sys) i_clk_en <= 1'b0;
        g_lb <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        chk(outs(2), 16'h01f4);
        i_clk_en <= 1'b1;
        g_lb <= 1'b0;
        @(posedge i_clk_sys) i_rst_n <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        rdchk(PA, 5'h14, 16'h0102);
        results();
    end
endmodule
